// >>> hw/dfc_params.svh
// constants for the dma channel flow control block
`ifndef DFC_PARAMS_SVH
`define DFC_PARAMS_SVH
// ------------------------------------------------------------
// channel command codes
// ------------------------------------------------------------
`define DFC_CMD_NO_EVENT_ACTION   2'h0
`define DFC_CMD_SUSPEND 2'h1
`define DFC_CMD_RESUME  2'h2
// ------------------------------------------------------------
// descriptor field codes
// ------------------------------------------------------------
`define DFC_BLKACT_SUSP   2'h2
`define DFC_BLKACT_BOTH   2'h3
`define DFC_EVOSEL_BLOCK  2'h1
`define DFC_EVOSEL_BEAT   2'h3
// ------------------------------------------------------------
// sizing and timing
// ------------------------------------------------------------
`define DFC_NUM_CH     8
`define DFC_NUM_EVCH   4
`define DFC_CLK_MHZ    100
`define DFC_EVPULSE_NS 10
`define DFC_EVPULSE_CYC ((`DFC_EVPULSE_NS * `DFC_CLK_MHZ) / 1000)
`endif

// >>> hw/dfc_pkg.sv
// types for the dma channel flow control block
package dfc_pkg;
   // ------------------------------------------------------------
   // event input actions
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      DFC_EV_NONE,
      DFC_EV_EVENT_TRIGGER_ACTION,
      DFC_EV_CONDITIONAL_TRIGGER_ACTION,
      DFC_EV_CONDITIONAL_BLOCK_ACTION,
      DFC_EV_SUSPEND,
      DFC_EV_RESUME,
      DFC_EV_SKIP_NEXT_SUSPEND_ACTION,
      DFC_EV_RSVD
   } dfc_evact_t;

   // ------------------------------------------------------------
   // per-channel configuration and status carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       event_input_enable;
      logic       event_output_enable;
      dfc_evact_t event_action_field;
      logic       trigger_source_enabled;
   } dfc_chcfg_t;

   typedef struct packed {
      logic       descriptor_valid_bit;
      logic [1:0] block_action_field;
      logic [1:0] event_output_select;
   } dfc_desc_t;

   typedef struct packed {
      logic [1:0] channel;
      logic       pulse;
   } dfc_evout_t;
endpackage : dfc_pkg

// >>> hw/dfc_evbuf.sv
// two-entry event output buffer, a stalled receiver loses no pulse until both entries are full
module dfc_evbuf
   import dfc_pkg::*;
#(
   parameter int WIDTH = 2,
   parameter int DEPTH = 2
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_mem    = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr      = bump(wr_ptr);
      end
      if (pop) begin
         next_rd_ptr = bump(rd_ptr);
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         mem    <= next_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // data leaves straight from the storage flops
   assign out_data = mem[rd_ptr];
endmodule : dfc_evbuf

// >>> hw/dfc_evpulse.sv
// stretches a request into an output event pulse of a fixed width
module dfc_evpulse
   import dfc_pkg::*;
#(
   parameter int CYCLES = 1
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic valid,
   output logic      ready,
   output logic      pulse
);
   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;
   logic [CW-1:0] left, next_left;

   // a new pulse only starts once the previous one is over
   assign ready = (left == '0);

   always_comb begin
      next_left = left;
      if (left != '0) begin
         next_left = left - 1'b1;
      end else if (valid) begin
         next_left = CW'(CYCLES);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         left  <= '0;
         pulse <= 1'b0;
      end else begin
         left  <= next_left;
         pulse <= (next_left != '0);
      end
   end
endmodule : dfc_evpulse

// >>> hw/dfc_flow.sv
// dma channel flow control: suspend, resume, event actions, event outputs, abort
`include "dfc_params.svh"
module dfc_flow
   import dfc_pkg::*;
#(
   parameter int NCH  = `DFC_NUM_CH,
   parameter int NEV  = `DFC_NUM_EVCH,
   parameter int EVW  = `DFC_EVPULSE_CYC
) (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire logic                 controller_enable_set,
   input  wire logic                 controller_disable_req,
   output logic                      controller_enable_bit,
   input  wire logic [NCH-1:0]       channel_enable_set,
   input  wire logic [NCH-1:0]       channel_disable_req,
   output logic      [NCH-1:0]       channel_enable_bit,
   input  wire logic [NCH-1:0][1:0]  command_write,
   input  wire logic [NCH-1:0]       command_strobe,
   output logic      [NCH-1:0][1:0]  channel_command_field,
   input  wire dfc_chcfg_t [NCH-1:0] channel_cfg,
   input  wire dfc_desc_t            active_desc,
   input  wire logic [2:0]           active_channel,
   input  wire logic                 active_busy,
   input  wire logic                 desc_fetched,
   input  wire logic                 burst_done,
   input  wire logic                 beat_done,
   input  wire logic                 block_done,
   input  wire logic                 writeback_done,
   input  wire logic [NCH-1:0]       periph_trigger,
   input  wire logic [NCH-1:0]       event_in,
   output logic      [NCH-1:0]       event_ack,
   output logic      [NCH-1:0]       channel_pending_bit,
   output logic      [NCH-1:0]       pending_channel_bit_n,
   input  wire logic [NCH-1:0]       transfer_started,
   output logic      [NCH-1:0]       channel_suspended,
   output logic      [NCH-1:0]       arbitration_mask,
   output logic      [NCH-1:0]       block_gate,
   output logic      [NCH-1:0]       channel_suspend_flag,
   input  wire logic [NCH-1:0]       suspend_flag_clear,
   output logic      [NCH-1:0]       fetch_error_bit,
   input  wire logic [NCH-1:0]       suspend_irq_enable,
   output logic      [NCH-1:0]       suspend_irq,
   output logic      [NEV-1:0]       event_out,
   output logic                      event_out_stall
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [NCH-1:0]      en, next_en, susp, next_susp, flag, next_flag, ferr, next_ferr;
   logic [NCH-1:0]      pend, next_pend, skip, next_skip, susreq, next_susreq;
   logic [NCH-1:0]      cblk, next_cblk, evsusp, next_evsusp, ack, next_ack;
   logic [NCH-1:0]      stop_req, next_stop_req;
   logic [NCH-1:0][1:0] cmd, next_cmd;
   logic                ctl_en, next_ctl_en;
   logic                bv, br;
   logic [1:0]          bd;
   logic [NEV-1:0]      pulse_ready;

   function automatic logic is_active(input logic [2:0] a, input int c);
      is_active = active_busy && (a == 3'(c));
   endfunction : is_active

   function automatic logic blk_suspends(input dfc_desc_t d);
      blk_suspends = (d.block_action_field == `DFC_BLKACT_SUSP) ||
                     (d.block_action_field == `DFC_BLKACT_BOTH);
   endfunction : blk_suspends

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic act, disreq, any_left, evon, cfl;
      dfc_evact_t ea;
      next_en       = en;
      next_susp     = susp;
      next_flag     = flag;
      next_ferr     = ferr;
      next_pend     = pend;
      next_skip     = skip;
      next_susreq   = susreq;
      next_cblk     = cblk;
      next_evsusp   = evsusp;
      next_ack      = '0;
      next_stop_req = stop_req;
      next_cmd      = cmd;
      next_ctl_en   = ctl_en | controller_enable_set;
      act = 1'b0;
      disreq = 1'b0;
      evon = 1'b0;
      cfl = 1'b0;
      ea = DFC_EV_NONE;
      any_left = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         act    = is_active(active_channel, c);
         disreq = channel_disable_req[c] || controller_disable_req || stop_req[c];
         evon   = (c < NEV) && channel_cfg[c].event_input_enable;
         ea     = channel_cfg[c].event_action_field;
         cfl    = 1'b0;
         if (channel_enable_set[c]) begin
            next_en[c] = 1'b1;
         end
         // software commands
         if (command_strobe[c]) begin
            next_cmd[c] = command_write[c];
         end
         if (cmd[c] == `DFC_CMD_SUSPEND) begin
            if (!en[c]) begin
               next_cmd[c] = `DFC_CMD_NO_EVENT_ACTION;
            end else if (skip[c]) begin
               next_skip[c] = 1'b0;
               next_cmd[c]  = `DFC_CMD_NO_EVENT_ACTION;
            end else if (!act || burst_done) begin
               next_susp[c] = 1'b1;
               next_cmd[c]  = `DFC_CMD_NO_EVENT_ACTION;
               cfl = 1'b1;
            end
         end else if (cmd[c] == `DFC_CMD_RESUME) begin
            next_cmd[c] = `DFC_CMD_NO_EVENT_ACTION;
            if (susp[c]) begin
               next_susp[c] = 1'b0;
            end else begin
               next_skip[c] = 1'b1;
            end
         end
         // event input actions
         if (evon && event_in[c]) begin
            unique case (ea)
               DFC_EV_EVENT_TRIGGER_ACTION: begin
                  if (!channel_cfg[c].trigger_source_enabled) begin
                     next_ack[c] = 1'b1;
                     next_pend[c] = 1'b1;
                  end else begin
                     next_ack[c] = 1'b1;
                     if (!pend[c] && periph_trigger[c]) begin
                        next_pend[c] = 1'b1;
                     end
                  end
               end
               DFC_EV_CONDITIONAL_TRIGGER_ACTION: begin
                  if (periph_trigger[c]) begin
                     next_pend[c] = 1'b1;
                     next_ack[c] = 1'b1;
                  end
               end
               DFC_EV_CONDITIONAL_BLOCK_ACTION: next_cblk[c] = 1'b1;
               DFC_EV_SUSPEND: if (en[c]) next_evsusp[c] = 1'b1;
               DFC_EV_RESUME: begin
                  next_ack[c]  = 1'b1;
                  next_susp[c] = 1'b0;
                  next_flag[c] = 1'b0;
               end
               DFC_EV_SKIP_NEXT_SUSPEND_ACTION: begin
                  if (susp[c]) begin
                     next_susp[c] = 1'b0;
                     next_ack[c]  = 1'b1;
                  end else begin
                     next_susreq[c] = 1'b1;
                  end
               end
               default: ;
            endcase
         end
         if (transfer_started[c]) begin
            next_pend[c] = 1'b0;
         end
         if (evsusp[c] && en[c] && (!act || burst_done)) begin
            next_evsusp[c] = 1'b0;
            next_ack[c]    = 1'b1;
            next_susp[c]   = 1'b1;
            cfl = 1'b1;
         end
         if (act && block_done) begin
            if (cblk[c]) begin
               next_cblk[c] = 1'b0;
               next_ack[c]  = 1'b1;
            end
            if (en[c] && blk_suspends(active_desc)) begin
               // a held skip event is acked here; a stored resume command has no event to ack
               if (susreq[c]) begin
                  next_susreq[c] = 1'b0;
                  next_ack[c]    = 1'b1;
               end else if (skip[c]) begin
                  next_skip[c] = 1'b0;
               end else begin
                  next_susp[c] = 1'b1;
                  cfl = 1'b1;
               end
            end
         end
         if (act && desc_fetched && !active_desc.descriptor_valid_bit && en[c]) begin
            next_susp[c] = 1'b1;
            next_ferr[c] = 1'b1;
            cfl = 1'b1;
         end
         // abort: the active channel waits for write-back, the rest go now
         if (en[c] && disreq) begin
            if (act && !writeback_done) begin
               next_stop_req[c] = 1'b1;
            end else begin
               next_en[c]       = 1'b0;
               next_stop_req[c] = 1'b0;
               next_susp[c]     = 1'b0;
               next_pend[c]     = 1'b0;
               next_evsusp[c]   = 1'b0;
            end
         end
         if (suspend_flag_clear[c]) begin
            next_flag[c] = 1'b0;
         end
         if (cfl) begin
            next_flag[c] = 1'b1;
         end
         any_left = any_left | next_en[c];
      end
      if (controller_disable_req && !any_left) begin
         next_ctl_en = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en       <= '0;
         susp     <= '0;
         flag     <= '0;
         ferr     <= '0;
         pend     <= '0;
         skip     <= '0;
         susreq   <= '0;
         cblk     <= '0;
         evsusp   <= '0;
         ack      <= '0;
         stop_req <= '0;
         cmd      <= '0;
         ctl_en   <= 1'b0;
      end else begin
         en       <= next_en;
         susp     <= next_susp;
         flag     <= next_flag;
         ferr     <= next_ferr;
         pend     <= next_pend;
         skip     <= next_skip;
         susreq   <= next_susreq;
         cblk     <= next_cblk;
         evsusp   <= next_evsusp;
         ack      <= next_ack;
         stop_req <= next_stop_req;
         cmd      <= next_cmd;
         ctl_en   <= next_ctl_en;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign controller_enable_bit = ctl_en;
   assign channel_enable_bit    = en;
   assign channel_command_field = cmd;
   assign event_ack             = ack;
   assign channel_pending_bit   = pend;
   assign pending_channel_bit_n = pend;
   assign channel_suspended     = susp;
   assign arbitration_mask      = en & ~susp;
   assign fetch_error_bit       = ferr;
   assign channel_suspend_flag  = flag;
   // a conditional block channel may not start until its event has come
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         block_gate[c] = !((c < NEV) && channel_cfg[c].event_input_enable &&
                           channel_cfg[c].event_action_field == DFC_EV_CONDITIONAL_BLOCK_ACTION && !cblk[c]);
      end
   end
   assign suspend_irq = flag & suspend_irq_enable & en;

   // ------------------------------------------------------------
   // event outputs
   // ------------------------------------------------------------
   always_comb begin
      bv = 1'b0;
      bd = active_channel[1:0];
      if (active_busy && (int'(active_channel) < NEV) &&
          channel_cfg[active_channel].event_output_enable) begin
         bv = (block_done && active_desc.event_output_select == `DFC_EVOSEL_BLOCK) ||
              (beat_done  && active_desc.event_output_select == `DFC_EVOSEL_BEAT);
      end
   end
   assign event_out_stall = !br;

   logic       qv;
   logic [1:0] qd;
   dfc_evbuf #(.WIDTH(2), .DEPTH(2)) u_buf (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (bv),
      .in_ready  (br),
      .in_data   (bd),
      .out_valid (qv),
      .out_ready (pulse_ready[qd]),
      .out_data  (qd)
   );
   for (genvar g = 0; g < NEV; g++) begin : g_evo
      dfc_evpulse #(.CYCLES(EVW)) u_pulse (
         .clock (clock),
         .rst_n (rst_n),
         .valid (qv && (qd == 2'(g))),
         .ready (pulse_ready[g]),
         .pulse (event_out[g])
      );
   end
endmodule : dfc_flow

// >>> verif/dfc_flow_assertions.sv
// concurrent checks on the dma channel flow control ports
module dfc_flow_assertions
   import dfc_pkg::*;
#(
   parameter int NCH = 8,
   parameter int NEV = 4
) (
   input wire logic                 clock,
   input wire logic                 rst_n,
   input wire logic [NCH-1:0][1:0]  command_write,
   input wire logic [NCH-1:0]       command_strobe,
   input wire logic [NCH-1:0][1:0]  channel_command_field,
   input wire logic [NCH-1:0]       channel_enable_bit,
   input wire logic [NCH-1:0]       channel_disable_req,
   input wire logic                 active_busy,
   input wire logic [2:0]           active_channel,
   input wire dfc_chcfg_t [NCH-1:0] channel_cfg,
   input wire logic [NCH-1:0]       event_in,
   input wire logic [NCH-1:0]       event_ack,
   input wire logic [NCH-1:0]       channel_suspended,
   input wire logic [NCH-1:0]       arbitration_mask,
   input wire logic [NCH-1:0]       channel_suspend_flag,
   input wire logic [NCH-1:0]       suspend_irq_enable,
   input wire logic [NCH-1:0]       suspend_irq,
   input wire logic [NCH-1:0]       fetch_error_bit,
   input wire logic [NEV-1:0]       event_out
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   sequence s_sus_req;
      command_strobe[0] && command_write[0] == 2'h1 && channel_enable_bit[0] && !active_busy;
   endsequence
   sequence s_sus_done;
      ##[1:3] (channel_suspended[0] && channel_command_field[0] == 2'h0);
   endsequence
   a_suspend_cmd_walk: assert property (s_sus_req |-> s_sus_done)
      else $error("suspend command did not complete");
   a_irq_follows_flag: assert property (suspend_irq ==
      (channel_suspend_flag & suspend_irq_enable & channel_enable_bit)) else $error("irq mismatch");
   a_arb_skips_suspended: assert property (arbitration_mask ==
      (channel_enable_bit & ~channel_suspended)) else $error("arbitration mask mismatch");
   a_high_ack_silent: assert property (event_ack[NCH-1:NEV] == '0)
      else $error("ack on channel without event input");
   a_evout_one_cycle: assert property ((event_out & $past(event_out)) == '0)
      else $error("event output longer than one cycle");
   a_fetch_err_sticky: assert property ((~fetch_error_bit & $past(fetch_error_bit)) == '0)
      else $error("fetch error dropped");
   a_only_enabled_sus: assert property ((channel_suspended & ~$past(channel_suspended)
      & ~$past(channel_enable_bit)) == '0) else $error("disabled channel suspended");
   a_idle_disable_next: assert property (channel_disable_req[3] &&
      !(active_busy && active_channel == 3'h3) |-> ##[1:2] !channel_enable_bit[3])
      else $error("idle channel not disabled");
   a_resume_event_ack: assert property (event_in[3] && channel_suspended[3] &&
      channel_cfg[3].event_input_enable && channel_cfg[3].event_action_field == DFC_EV_RESUME
      |-> ##[1:2] event_ack[3]) else $error("resume event not acknowledged");
endmodule : dfc_flow_assertions

bind dfc_flow dfc_flow_assertions #(.NCH(NCH), .NEV(NEV)) i_dfc_flow_assertions (.clock, .rst_n,
   .command_write, .command_strobe, .channel_command_field, .channel_enable_bit, .channel_disable_req,
   .active_busy, .active_channel, .channel_cfg, .event_in, .event_ack, .channel_suspended,
   .arbitration_mask, .channel_suspend_flag, .suspend_irq_enable, .suspend_irq, .fetch_error_bit,
   .event_out);

// >>> verif/dfc_far_model.sv
// bus side model: descriptor fetch, beats with wait states, block end, write-back
module dfc_far_model (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [3:0] gap,
   output logic            busy,
   output logic            fetched,
   output logic            beat,
   output logic            blk,
   output logic            wb
);
   // write-back always trails the last beat, the abort path relies on it
   initial begin
      {busy, fetched, beat, blk, wb} = '0;
      forever begin
         @(posedge clock);
         if (go && rst_n) begin
            busy    <= 1'h1;
            fetched <= 1'h1;
            @(posedge clock);
            fetched <= 1'h0;
            repeat (2) begin
               repeat (gap) begin
                  beat <= 1'h0;
                  @(posedge clock);
               end
               beat <= 1'h1;
               @(posedge clock);
            end
            beat <= 1'h0;
            blk  <= 1'h1;
            @(posedge clock);
            blk <= 1'h0;
            wb  <= 1'h1;
            @(posedge clock);
            {wb, busy} <= '0;
         end
      end
   end
endmodule : dfc_far_model

// >>> verif/dfc_flow_bench.sv
// self-checking testbench for the dma channel flow control block
module dfc_flow_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import dfc_pkg::*;
   logic clock = 0, rst_n = 0, ces = 0, cdr = 0, go = 0, clr = 0;
   logic [7:0] ces_ch = '0, cdr_ch = '0, cstb = '0, trg = '0, evin = '0, tst = '0, sfc = '0;
   logic [7:0] irqen = 8'hff, en, ack, pnd, pndn, sus, am, gt, sf, fe, irq, ack_seen = '0;
   logic [7:0][1:0] cw = '0, cf;
   dfc_chcfg_t [7:0] cfg = '0;
   dfc_desc_t desc = '0;
   logic [2:0] ach = '0;
   logic [3:0] eo, gap = '0;
   logic ceb, stall, busy, fch, beat, blk, wb;
   int failures = 0, num_checks = 0, ev_cnt = 0;
   always #5 clock = ~clock;
   always @(posedge clock) begin
      ack_seen <= clr ? '0 : (ack_seen | ack);
      ev_cnt   <= clr ? 0 : ev_cnt + int'(eo[0]);
   end
   dfc_flow i_dfc_flow (.clock, .rst_n, .controller_enable_set(ces), .controller_disable_req(cdr),
      .controller_enable_bit(ceb), .channel_enable_set(ces_ch), .channel_disable_req(cdr_ch),
      .channel_enable_bit(en), .command_write(cw), .command_strobe(cstb), .channel_command_field(cf),
      .channel_cfg(cfg), .active_desc(desc), .active_channel(ach), .active_busy(busy),
      .desc_fetched(fch), .burst_done(beat), .beat_done(beat), .block_done(blk), .writeback_done(wb),
      .periph_trigger(trg), .event_in(evin), .event_ack(ack), .channel_pending_bit(pnd),
      .pending_channel_bit_n(pndn), .transfer_started(tst), .channel_suspended(sus),
      .arbitration_mask(am), .block_gate(gt), .channel_suspend_flag(sf), .suspend_flag_clear(sfc),
      .fetch_error_bit(fe), .suspend_irq_enable(irqen), .suspend_irq(irq), .event_out(eo),
      .event_out_stall(stall));
   dfc_far_model i_dfc_far_model (.clock, .rst_n, .go, .gap, .busy, .fetched(fch), .beat, .blk, .wb);
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic cmd(input int c, input logic [1:0] v);
      @(posedge clock);
      cstb[c] <= 1'h1;
      cw[c]   <= v;
      @(posedge clock);
      cstb[c] <= 1'h0;
   endtask : cmd
   task automatic ev(input int c);
      @(posedge clock);
      evin[c] <= 1'h1;
      @(posedge clock);
      evin[c] <= 1'h0;
   endtask : ev
   task automatic run(input dfc_desc_t d, input int w);
      desc <= d;
      clr  <= 1'h1;
      @(posedge clock);
      go  <= 1'h1;
      clr <= 1'h0;
      @(posedge clock);
      go <= 1'h0;
      cyc(w);
   endtask : run
   task automatic test_done;
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial begin
      #20000;
      failures++;
      test_done();
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      cfg[2] = '{1'h1, 1'h0, DFC_EV_EVENT_TRIGGER_ACTION, 1'h0};
      cfg[5] = cfg[2];
      cfg[3] = '{1'h1, 1'h0, DFC_EV_RESUME, 1'h0};
      cfg[0].event_output_enable = 1'h1;
      cyc(4);
      chk("reset_enable", en, 8'h00);
      rst_n <= 1'h1;
      @(posedge clock);
      {ces, ces_ch} <= {1'h1, 8'h3f};
      @(posedge clock);
      {ces, ces_ch} <= '0;
      cyc(2);
      chk("enable", {ceb, en[6:0]}, 8'hbf);
      cmd(0, 2'h1);
      cyc(3);
      chk("sus_cmd", {sus[0], sf[0], irq[0], cf[0]}, 8'h1c);
      cmd(0, 2'h2);
      @(posedge clock);
      sfc[0] <= 1'h1;
      @(posedge clock);
      sfc[0] <= 1'h0;
      cyc(2);
      chk("resume", {sus[0], sf[0], irq[0]}, 8'h00);
      cmd(6, 2'h1);
      cyc(3);
      chk("sus_off", {sus[6], cf[6]}, 8'h00);
      cmd(1, 2'h2);
      cmd(1, 2'h1);
      cyc(4);
      chk("skip", sus[1], 8'h00);
      ev(2);
      cyc(2);
      chk("event_trigger_action", {pnd[2], pndn[2], ack_seen[2]}, 8'h07);
      clr <= 1'h1;
      @(posedge clock);
      clr <= 1'h0;
      ev(2);
      ev(5);
      cyc(2);
      chk("event_trigger_action_lost", {ack_seen[2], ack_seen[5], pnd[5]}, 8'h04);
      cmd(3, 2'h1);
      cyc(3);
      ev(3);
      cyc(3);
      chk("resume_ev", {sus[3], sf[3], ack_seen[3]}, 8'h01);
      cfg[1] <= '{1'h1, 1'h0, DFC_EV_EVENT_TRIGGER_ACTION, 1'h1};
      ev(1);
      cyc(2);
      chk("strobe_idle", pnd[1], 8'h00);
      trg[1] <= 1'h1;
      ev(1);
      cyc(2);
      chk("strobe_hit", pnd[1], 8'h01);
      tst[1] <= 1'h1;
      cfg[1].event_action_field <= DFC_EV_CONDITIONAL_TRIGGER_ACTION;
      @(posedge clock);
      tst[1] <= 1'h0;
      cyc(1);
      chk("started", pnd[1], 8'h00);
      ev(1);
      cyc(2);
      chk("conditional_trigger_action", pnd[1], 8'h01);
      cfg[1].event_action_field <= DFC_EV_SUSPEND;
      ev(1);
      cyc(3);
      chk("sus_ev", {sus[1], sf[1]}, 8'h03);
      cfg[1].event_action_field <= DFC_EV_SKIP_NEXT_SUSPEND_ACTION;
      ev(1);
      cyc(2);
      chk("skip_ev", sus[1], 8'h00);
      run('{1'h1, 2'h2, 2'h1}, 10);
      chk("blk_sus", {sus[0], am[0], en[0], ev_cnt[4:0]}, 8'ha1);
      cmd(0, 2'h2);
      cfg[0] <= '{1'h1, 1'h1, DFC_EV_CONDITIONAL_BLOCK_ACTION, 1'h0};
      cyc(1);
      chk("cblk_gate", gt, 8'hfe);
      ev(0);
      cyc(2);
      chk("cblk_wait", {gt[0], ack_seen[0]}, 8'h02);
      gap = 4'h3;
      run('{1'h1, 2'h0, 2'h3}, 20);
      chk("beat_ev", ev_cnt[7:0], 8'h02);
      chk("cblk_done", {gt[0], ack_seen[0]}, 8'h01);
      gap = 4'h0;
      cfg[0].event_action_field <= DFC_EV_SKIP_NEXT_SUSPEND_ACTION;
      ev(0);
      run('{1'h1, 2'h2, 2'h0}, 10);
      chk("skip_blk", {sus[0], ack_seen[0]}, 8'h01);
      run('{1'h0, 2'h0, 2'h0}, 10);
      chk("invalid", {fe[0], sus[0]}, 8'h03);
      cmd(0, 2'h2);
      run('{1'h1, 2'h0, 2'h0}, 1);
      cdr_ch[3:0] <= 4'h9;
      @(posedge clock);
      cdr_ch <= '0;
      cyc(2);
      chk("abort_mid", en[3:0], 8'h07);
      cyc(10);
      chk("abort_end", en[0], 8'h00);
      cdr <= 1'h1;
      cyc(6);
      chk("ctrl_off", en, 8'h00);
      chk("ctrl_en_off", {7'h00, ceb}, 8'h00);
      chk("no_stall", {7'h00, stall}, 8'h00);
      test_done();
   end
endmodule : dfc_flow_bench
